// ---- dv/tic_top_tb_top.sv ----
`timescale 1ns/1ps

module tic_top_tb_top;
    import tic_pkg::*;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic tick_128 = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic irq_en = 1'b0;
    logic interval_irq;
    int fails = 0;
    int compares = 0;

    tic_top tic_top_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick_128(tick_128),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .interval_irq_enable(irq_en),
        .interval_irq(interval_irq)
    );

    // Clock at 100 MHz
    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One register write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask

    // Read with one cycle of latency, then compare
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        @(negedge ref_clk);
        chk(sfr_rdata, exp);
    endtask

    // Tick pulses of one cycle each
    task automatic tick(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            tick_128 = 1'b1;
            @(negedge ref_clk);
            tick_128 = 1'b0;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values and an unmapped address
    task automatic reset_values();
        for (int a = 8'ha1; a <= 8'ha6; a++)
            rd(8'(a), 8'h00);
        rd(8'hb0, 8'h00);
    endtask

    // Preload, refused writes, cascade and clear
    task automatic time_chain();
        wr(TIC_ADDR_SECONDS, 8'h3b);
        wr(TIC_ADDR_MINUTES, 8'h3b);
        wr(TIC_ADDR_HOURS, 8'h17);
        wr(TIC_ADDR_FRACTION, 8'h7e);
        rd(TIC_ADDR_HOURS, 8'h17);
        tick(1);
        rd(TIC_ADDR_FRACTION, 8'h7e);
        wr(TIC_ADDR_CONTROL, 8'h41);
        wr(TIC_ADDR_SECONDS, 8'h05);
        rd(TIC_ADDR_SECONDS, 8'h3b);
        tick(1);
        rd(TIC_ADDR_FRACTION, 8'h7f);
        tick(1);
        rd(TIC_ADDR_FRACTION, 8'h00);
        rd(TIC_ADDR_SECONDS, 8'h00);
        rd(TIC_ADDR_MINUTES, 8'h00);
        rd(TIC_ADDR_HOURS, 8'h00);
        tick(3);
        rd(TIC_ADDR_FRACTION, 8'h03);
        wr(TIC_ADDR_CONTROL, 8'h40);
        rd(TIC_ADDR_FRACTION, 8'h00);
        tick(1);
        rd(TIC_ADDR_FRACTION, 8'h00);
    endtask

    // Periodic match with sticky flag and interrupt
    task automatic auto_reload();
        wr(TIC_ADDR_TARGET, 8'h02);
        wr(TIC_ADDR_CONTROL, 8'h43);
        irq_en = 1'b1;
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h43);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h47);
        chk({7'h00, interval_irq}, 8'h01);
        @(negedge ref_clk);
        irq_en = 1'b0;
        @(negedge ref_clk);
        chk({7'h00, interval_irq}, 8'h00);
        irq_en = 1'b1;
        wr(TIC_ADDR_CONTROL, 8'h43);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h43);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h47);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h47);
        wr(TIC_ADDR_CONTROL, 8'h40);
    endtask

    // One-shot timeout drops the count enable
    task automatic one_shot();
        wr(TIC_ADDR_TARGET, 8'h01);
        wr(TIC_ADDR_CONTROL, 8'h4b);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h4d);
        wr(TIC_ADDR_CONTROL, 8'h49);
        tick(2);
        rd(TIC_ADDR_CONTROL, 8'h49);
        wr(TIC_ADDR_CONTROL, 8'h40);
    endtask

    // Clearing count enable zeroes the count; target change applies at once
    task automatic count_clear();
        wr(TIC_ADDR_TARGET, 8'h03);
        wr(TIC_ADDR_CONTROL, 8'h43);
        tick(2);
        wr(TIC_ADDR_CONTROL, 8'h41);
        wr(TIC_ADDR_CONTROL, 8'h43);
        tick(2);
        rd(TIC_ADDR_CONTROL, 8'h43);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h47);
        wr(TIC_ADDR_CONTROL, 8'h43);
        wr(TIC_ADDR_TARGET, 8'h05);
        tick(1);
        wr(TIC_ADDR_TARGET, 8'h02);
        tick(1);
        rd(TIC_ADDR_CONTROL, 8'h47);
        wr(TIC_ADDR_CONTROL, 8'h40);
    endtask

    // Each slower timebase steps on its rollover
    task automatic timebase_sel();
        logic [7:0] c;
        for (int s = 1; s <= 3; s++)
        begin
            c = 8'h43 | 8'(s << 4);
            wr(TIC_ADDR_CONTROL, 8'h40);
            wr(TIC_ADDR_TARGET, 8'h01);
            wr(TIC_ADDR_FRACTION, 8'h7e);
            if (s > 1)
                wr(TIC_ADDR_SECONDS, 8'h3b);
            if (s > 2)
                wr(TIC_ADDR_MINUTES, 8'h3b);
            wr(TIC_ADDR_CONTROL, c);
            tick(1);
            rd(TIC_ADDR_CONTROL, c);
            tick(1);
            rd(TIC_ADDR_CONTROL, c | 8'h04);
        end
        wr(TIC_ADDR_CONTROL, 8'h40);
    endtask

    // Reset in mid-run clears control, time and target
    task automatic mid_reset();
        wr(TIC_ADDR_TARGET, 8'h09);
        wr(TIC_ADDR_FRACTION, 8'h11);
        wr(TIC_ADDR_CONTROL, 8'hc0);
        rd(TIC_ADDR_CONTROL, 8'hc0);
        @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        rd(TIC_ADDR_TARGET, 8'h00);
        rd(TIC_ADDR_FRACTION, 8'h00);
        rd(TIC_ADDR_CONTROL, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reset, then run every scenario
    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        reset_values();
        time_chain();
        auto_reload();
        one_shot();
        count_clear();
        timebase_sel();
        mid_reset();
        give_verdict();
    end
endmodule

// ---- hdl/tic_top.sv ----
`timescale 1ns/1ps

// Notes on behaviour
// - timebase select: tick, second, minute, hour
// - one-shot timeout clears interval count enable
// - otherwise counter reloads and keeps counting
// - match sets sticky flag; only software clears
// - flag raises interrupt when outside enable active
// - count enable starts; clearing stops and zeroes
// - timebase enable gates tick to all counters
// - clearing timebase enable stops and clears registers
// - time registers writable while timebase disabled
// - fraction counts 0..127 each tick, carries
// - seconds count 0..59, carry to minutes
// - minutes count 0..59, carry to hours
// - hours count 0..23, no carry out
// - power-on clears time and target registers
// - interval steps on each tick or on selected register rollover
// - chain driven by always-running crystal tick
module tic_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Tick from the crystal domain, one pulse per 1/128 s
    input wire logic tick_128,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Interrupt
    input wire logic interval_irq_enable,
    output logic interval_irq
);
    import tic_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic rsv7;
        logic rsv6;
        logic [1:0] timebase_sel;
        logic one_shot_mode;
        logic interval_match_flag;
        logic interval_count_enable;
        logic timebase_clock_enable;
        logic [7:0] interval_target;
        logic [7:0] interval_count;
        logic [7:0] rdata;
    } tic_state_s;

    tic_state_s st_reg;
    tic_state_s st_next;

    logic [7:0] ctrl_value;
    logic ctrl_wr;
    logic time_clear;
    logic tick_on;
    logic iv_step;
    logic [7:0] iv_inc;
    logic match_evt;
    logic [7:0] time_value [TIC_STAGES];
    logic time_step [TIC_STAGES];
    logic time_wrap [TIC_STAGES];
    logic time_load [TIC_STAGES];
    logic [7:0] time_max [TIC_STAGES];

    // -------------------------------------------------------------
    // Decode and gating
    // -------------------------------------------------------------
    assign ctrl_wr = sfr_wr && (sfr_addr == TIC_ADDR_CONTROL);
    // Falling timebase enable clears the chain
    assign time_clear = ctrl_wr && st_reg.timebase_clock_enable
                        && !sfr_wdata[TIC_BIT_TB_EN];
    // Crystal tick reaches the chain only when enabled
    assign tick_on = tick_128 && st_reg.timebase_clock_enable;

    assign time_max[0] = TIC_MAX_FRACTION;
    assign time_max[1] = TIC_MAX_SECONDS;
    assign time_max[2] = TIC_MAX_MINUTES;
    assign time_max[3] = TIC_MAX_HOURS;

    // -------------------------------------------------------------
    // Time-of-day chain
    // -------------------------------------------------------------
    for (genvar i = 0; i < TIC_STAGES; i++)
    begin : g_stage
        if (i == 0)
        begin : g_first
            assign time_step[i] = tick_on;
        end
        else
        begin : g_carry
            assign time_step[i] = time_wrap[i-1];
        end
        // Preload only while the timebase is off
        assign time_load[i] = sfr_wr && !st_reg.timebase_clock_enable
            && (sfr_addr == TIC_ADDR_FRACTION + 8'(i));
        tic_wrap_counter #(
            .WIDTH(8),
            .MAX_VALUE(i == 0 ? TIC_MAX_FRACTION :
                       i == 1 ? TIC_MAX_SECONDS :
                       i == 2 ? TIC_MAX_MINUTES : TIC_MAX_HOURS)
        ) tic_wrap_counter_inst (
            .ref_clk(ref_clk),
            .rst(rst),
            .clear(time_clear),
            .load(time_load[i]),
            .load_value(sfr_wdata),
            .step(time_step[i]),
            .value(time_value[i]),
            .wrap(time_wrap[i])
        );

        // Each stage rolls to zero from its own limit and pulses its wrap output
        stage_wrap_a: assert property (
            @(posedge ref_clk) disable iff (rst)
            time_step[i] && !time_clear && !time_load[i]
            && time_value[i] == time_max[i]
            |-> time_wrap[i] ##1 time_value[i] == 8'h00)
            else $error("time stage did not roll over");
    end

    // -------------------------------------------------------------
    // Interval step source and match
    // -------------------------------------------------------------
    // Pick the tick or rollover that paces the interval counter
    always_comb
    begin
        case (st_reg.timebase_sel)
            TIC_TB_TICK: iv_step = tick_on;
            TIC_TB_SECOND: iv_step = time_wrap[0];
            TIC_TB_MINUTE: iv_step = time_wrap[1];
            TIC_TB_HOUR: iv_step = time_wrap[2];
            default: iv_step = 1'b0;
        endcase
    end

    // Compare with the live target, no restart needed
    assign iv_inc = st_reg.interval_count + 8'h01;
    assign match_evt = iv_step && st_reg.interval_count_enable
                       && (iv_inc == st_reg.interval_target);

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        // Interval counter advance, reload or one-shot stop
        if (st_reg.interval_count_enable && iv_step)
        begin
            if (match_evt)
            begin
                st_next.interval_count = TIC_RST_COUNT;
                if (st_reg.one_shot_mode)
                    st_next.interval_count_enable = 1'b0;
            end
            else
            begin
                st_next.interval_count = iv_inc;
            end
        end
        if (match_evt)
            st_next.interval_match_flag = 1'b1;
        // Software write to control; a same-cycle match still sets flag
        if (ctrl_wr)
        begin
            st_next.rsv7 = sfr_wdata[TIC_BIT_RSV7];
            st_next.rsv6 = sfr_wdata[TIC_BIT_RSV6];
            st_next.timebase_sel = sfr_wdata[TIC_BIT_ITS_HI:TIC_BIT_ITS_LO];
            st_next.one_shot_mode = sfr_wdata[TIC_BIT_ONE_SHOT];
            st_next.interval_match_flag = sfr_wdata[TIC_BIT_MATCH]
                                          || match_evt;
            st_next.interval_count_enable = sfr_wdata[TIC_BIT_IV_EN];
            st_next.timebase_clock_enable = sfr_wdata[TIC_BIT_TB_EN];
        end
        // Disabled counter holds zero timebase off clears it too
        if (!st_next.interval_count_enable || time_clear)
            st_next.interval_count = TIC_RST_COUNT;
        // Target takes any 8-bit value
        if (sfr_wr && sfr_addr == TIC_ADDR_TARGET)
            st_next.interval_target = sfr_wdata;
        // Read data register follows the address
        if (sfr_addr == TIC_ADDR_CONTROL)
            st_next.rdata = ctrl_value;
        else if (sfr_addr == TIC_ADDR_FRACTION)
            st_next.rdata = time_value[0];
        else if (sfr_addr == TIC_ADDR_SECONDS)
            st_next.rdata = time_value[1];
        else if (sfr_addr == TIC_ADDR_MINUTES)
            st_next.rdata = time_value[2];
        else if (sfr_addr == TIC_ADDR_HOURS)
            st_next.rdata = time_value[3];
        else if (sfr_addr == TIC_ADDR_TARGET)
            st_next.rdata = st_reg.interval_target;
        else
            st_next.rdata = 8'h00;
    end

    // Control register as read back
    assign ctrl_value = {st_reg.rsv7, st_reg.rsv6, st_reg.timebase_sel,
                         st_reg.one_shot_mode, st_reg.interval_match_flag,
                         st_reg.interval_count_enable,
                         st_reg.timebase_clock_enable};

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.interval_target <= TIC_RST_TARGET;
            {st_reg.rsv7, st_reg.rsv6, st_reg.timebase_sel,
             st_reg.one_shot_mode, st_reg.interval_match_flag,
             st_reg.interval_count_enable,
             st_reg.timebase_clock_enable} <= TIC_RST_CONTROL;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign sfr_rdata = st_reg.rdata;
    // Interrupt request gated by the outside enable
    assign interval_irq = st_reg.interval_match_flag && interval_irq_enable;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    match_sets_flag_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        match_evt |=> st_reg.interval_match_flag)
        else $error("match did not set the flag");

    flag_sticky_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        st_reg.interval_match_flag && !ctrl_wr
        |=> st_reg.interval_match_flag)
        else $error("flag cleared without software");

    one_shot_stop_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        match_evt && st_reg.one_shot_mode && !ctrl_wr
        |=> !st_reg.interval_count_enable && st_reg.interval_count == 8'h00)
        else $error("one-shot did not stop counting");

    auto_reload_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        match_evt && !st_reg.one_shot_mode && !ctrl_wr && !time_clear
        |=> st_reg.interval_count_enable && st_reg.interval_count == 8'h00)
        else $error("auto-reload did not restart");

    count_zero_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !st_reg.interval_count_enable |-> st_reg.interval_count == 8'h00)
        else $error("disabled counter not zero");

    irq_follows_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        match_evt && interval_irq_enable ##1 interval_irq_enable
        |-> interval_irq)
        else $error("interrupt not raised on match");

    chain_cleared_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        time_clear |=> time_value[0] == 8'h00 && time_value[1] == 8'h00
        && time_value[2] == 8'h00 && time_value[3] == 8'h00)
        else $error("time registers not cleared");

    chain_frozen_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !st_reg.timebase_clock_enable && !sfr_wr
        |=> $stable(time_value[0]) && $stable(st_reg.interval_count))
        else $error("chain moved while disabled");

    fraction_wrap_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        tick_on && !sfr_wr && time_value[0] == 8'h7f
        && time_value[1] == 8'h00
        |=> time_value[0] == 8'h00 && time_value[1] == 8'h01)
        else $error("fraction did not carry");

    hour_wrap_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        time_step[3] && !sfr_wr && time_value[3] == 8'h17
        |=> time_value[3] == 8'h00)
        else $error("hours did not wrap at 23");

    tick_step_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        st_reg.interval_count_enable && !ctrl_wr && tick_on
        && st_reg.timebase_sel == TIC_TB_TICK && !match_evt
        |=> st_reg.interval_count == $past(st_reg.interval_count) + 8'h01)
        else $error("interval count missed a tick");

    slow_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        st_reg.interval_count_enable && !ctrl_wr && !time_wrap[0]
        && st_reg.timebase_sel != TIC_TB_TICK
        |=> $stable(st_reg.interval_count))
        else $error("slow timebase stepped without rollover");

    preload_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        sfr_wr && !st_reg.timebase_clock_enable
        && sfr_addr == TIC_ADDR_MINUTES
        |=> time_value[2] == $past(sfr_wdata))
        else $error("preload write not accepted");

    preload_refused_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        sfr_wr && st_reg.timebase_clock_enable && !tick_on
        && sfr_addr == TIC_ADDR_SECONDS
        |=> $stable(time_value[1]))
        else $error("time written while running");

    flag_cause_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !st_reg.interval_match_flag && !match_evt && !ctrl_wr
        |=> !st_reg.interval_match_flag)
        else $error("flag set without a match");

    irq_gated_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !interval_irq_enable || !st_reg.interval_match_flag
        |-> !interval_irq)
        else $error("interrupt raised without enable and flag");

    // Reset is watched itself, so this check has no disable
    reset_clear_a: assert property (
        @(posedge ref_clk)
        rst |=> st_reg.interval_target == TIC_RST_TARGET
        && time_value[3] == TIC_RST_TIME && ctrl_value == TIC_RST_CONTROL)
        else $error("reset left a register set");

endmodule

// ---- hdl/tic_wrap_counter.sv ----
`timescale 1ns/1ps

// One stage of the time-of-day chain: counts 0..MAX_VALUE, then wraps
module tic_wrap_counter #(
    parameter int WIDTH = 8,
    parameter logic [7:0] MAX_VALUE = 8'h7f
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic step,
    // Result
    output logic [WIDTH-1:0] value,
    output logic wrap
);
    import tic_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
    } tic_stage_s;

    tic_stage_s st_reg;
    tic_stage_s st_next;

    // Refuse limits that the counter width cannot hold
    if (WIDTH < 1 || WIDTH > 8 || int'(MAX_VALUE) >= (1 << WIDTH))
    begin : bad_param
        $error("tic_wrap_counter: MAX_VALUE does not fit WIDTH");
    end

    // Wrap pulse marks the step that rolls over to zero
    assign wrap = step && !clear && !load
                  && (st_reg.count == MAX_VALUE[WIDTH-1:0]);
    assign value = st_reg.count;

    // Clear beats load, load beats the step
    always_comb
    begin
        st_next = st_reg;
        if (clear)
        begin
            st_next.count = '0;
        end
        else if (load)
        begin
            st_next.count = load_value;
        end
        else if (step)
        begin
            if (st_reg.count == MAX_VALUE[WIDTH-1:0])
                st_next.count = '0;
            else
                st_next.count = st_reg.count + 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            st_reg.count <= TIC_RST_TIME[WIDTH-1:0];
        else
            st_reg <= st_next;
    end

endmodule

// ---- shared/tic_pkg.sv ----
package tic_pkg;

    // -------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------
    localparam logic [7:0] TIC_ADDR_CONTROL = 8'ha1;
    localparam logic [7:0] TIC_ADDR_FRACTION = 8'ha2;
    localparam logic [7:0] TIC_ADDR_SECONDS = 8'ha3;
    localparam logic [7:0] TIC_ADDR_MINUTES = 8'ha4;
    localparam logic [7:0] TIC_ADDR_HOURS = 8'ha5;
    localparam logic [7:0] TIC_ADDR_TARGET = 8'ha6;

    // -------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------
    localparam int TIC_BIT_TB_EN = 0;
    localparam int TIC_BIT_IV_EN = 1;
    localparam int TIC_BIT_MATCH = 2;
    localparam int TIC_BIT_ONE_SHOT = 3;
    localparam int TIC_BIT_ITS_LO = 4;
    localparam int TIC_BIT_ITS_HI = 5;
    localparam int TIC_BIT_RSV6 = 6;
    localparam int TIC_BIT_RSV7 = 7;

    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [7:0] TIC_RST_CONTROL = 8'h00;
    localparam logic [7:0] TIC_RST_TIME = 8'h00;
    localparam logic [7:0] TIC_RST_TARGET = 8'h00;
    localparam logic [7:0] TIC_RST_COUNT = 8'h00;

    // -------------------------------------------------------------
    // Counting limits of the time chain
    // -------------------------------------------------------------
    localparam int TIC_STAGES = 4;
    localparam logic [7:0] TIC_MAX_FRACTION = 8'h7f;
    localparam logic [7:0] TIC_MAX_SECONDS = 8'h3b;
    localparam logic [7:0] TIC_MAX_MINUTES = 8'h3b;
    localparam logic [7:0] TIC_MAX_HOURS = 8'h17;

    // -------------------------------------------------------------
    // Timebase select codes
    // -------------------------------------------------------------
    localparam logic [1:0] TIC_TB_TICK = 2'h0;
    localparam logic [1:0] TIC_TB_SECOND = 2'h1;
    localparam logic [1:0] TIC_TB_MINUTE = 2'h2;
    localparam logic [1:0] TIC_TB_HOUR = 2'h3;

endpackage
